//--- core/mcu_reset_regs.vh
`ifndef MCU_RESET_REGS_VH
`define MCU_RESET_REGS_VH

// Clock period of pclk in ns
`define CLK_PERIOD_NS      4

// Start-up and qualification times in ns
`define POR_DELAY_NS       50000000
`define PIN_DELAY_NS       16700000
`define LVR_QUAL_NS        100000

// Times above as whole pclk cycles, sized for the 24-bit timer
`define POR_DELAY_CYC      24'hBEBC20
`define PIN_DELAY_CYC      24'h3FB498
`define LVR_QUAL_CYC       24'h0061A8

// Low-speed RC ticks from qualified low supply to reset
`define LVR_TICKS          2'h2

// Register byte offsets
`define OFS_PIN_SEL        8'h00
`define OFS_SYSTEM_MODE_CONTROL_1          8'h04
`define OFS_STATUS         8'h08

// Reset pin select values
`define PSEL_RST           8'h55
`define PSEL_KEY_PORT      8'h55
`define PSEL_KEY_RES       8'hAA
`define PSEL_WMASK         8'hFF

// System mode control 1 fields
`define SM1_RST            8'h00
`define SM1_WMASK          8'h88
`define SM1_LOW_VOLTAGE_RESET_FLAG           2
`define SM1_WRF            0

// Status register fields
`define STS_TO             0
`define STS_PDF            1
`define STS_PIN_RES        2
`define STS_LVR_EN         3
`define STS_HOLD           4

`endif

//--- core/startup_timer.v
`timescale 1ns/1ps
`default_nettype none

module startup_timer (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Load request
    input  wire        start,
    input  wire [23:0] load_value,
    // Count-out pulse
    output wire        done
);

    reg  [23:0] count_ff;   // Cycles still to wait
    reg         done_ff;    // High one cycle at count-out
    wire [23:0] load_min;   // Load value, never below one

    // A zero load would never count out
    assign load_min = (load_value == 24'h000000) ? 24'h000001 : load_value;
    assign done     = done_ff;

    // Down counter, reloaded by start
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 24'h000000;
            done_ff  <= 1'b0;
        end else if (start) begin
            // Restart wins over a running count
            count_ff <= load_min;
            done_ff  <= 1'b0;
        end else if (count_ff != 24'h000000) begin
            count_ff <= count_ff - 24'h000001;
            done_ff  <= (count_ff == 24'h000001);
        end else begin
            done_ff  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- core/mcu_reset_sequencer.v
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "mcu_reset_regs.vh"

module mcu_reset_sequencer #(
    parameter [23:0] POR_DELAY_CYC = `POR_DELAY_CYC,
    parameter [23:0] PIN_DELAY_CYC = `PIN_DELAY_CYC,
    parameter [23:0] LVR_QUAL_CYC  = `LVR_QUAL_CYC
) (
    // Clock and power-on reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Pins and supply monitor
    input  wire        external_reset_pin_n,
    input  wire        supply_low,
    input  wire        low_speed_rc_tick,
    // Core events
    input  wire        sleep_idle_mode,
    input  wire        watchdog_timeout,
    input  wire        watchdog_ctrl_soft_reset,
    input  wire        halt_exec,
    input  wire        clear_wdt_exec,
    // Reset outputs to core
    output wire        core_hold,
    output wire        cold_reset,
    output wire        pc_sp_clear,
    output wire        wdt_restart,
    output wire        lvr_monitor_en,
    output wire        pin_is_reset,
    // Reset flags
    output wire        watchdog_timeout_flag,
    output wire        power_down_flag
);

    // One-hot sequencer states
    localparam [3:0] ST_RUN   = 4'h1;   // Executing
    localparam [3:0] ST_PIN   = 4'h2;   // Reset pin held low
    localparam [3:0] ST_DELAY = 4'h4;   // Start-up timer running
    localparam [3:0] ST_LVRW  = 4'h8;   // Waiting low-speed ticks

    reg  [3:0]  state_ff;               // Sequencer state
    reg  [3:0]  nxt_state;              // Next state
    reg         por_pending_ff;         // Power-on delay not yet started
    reg         tmr_start_ff;           // Start-up timer load strobe
    reg  [23:0] tmr_load_ff;            // Start-up timer load value
    reg         nxt_start;              // Next load strobe
    reg  [23:0] nxt_load;               // Next load value
    wire        tmr_done;               // Start-up timer count-out

    reg         core_hold_ff;           // Execution inhibited
    reg         cold_reset_ff;          // Power-on reset in progress
    reg         pc_sp_clear_ff;         // PC and SP clear pulse
    reg         wdt_restart_ff;         // Watchdog clear pulse
    reg         lvr_en_ff;              // Supply monitor enabled
    reg  [23:0] lvr_cnt_ff;             // Low supply duration
    reg  [1:0]  lvr_tick_ff;            // Ticks seen after qualify

    reg  [7:0]  pin_sel_ff;             // Reset pin select
    reg         pin_is_reset_ff;        // Pin select holds reset key
    reg  [7:0]  system_mode_control_1_ff;               // System mode control 1
    reg         to_flag_ff;             // Watchdog time-out flag
    reg         pdf_flag_ff;            // Power-down flag

    reg  [31:0] prdata_ff;              // Read data
    reg         pready_ff;              // Access answer
    reg         pslverr_ff;             // Unmapped access
    reg  [31:0] rd_mux;                 // Read data source

    wire        pin_low;                // Pin acting as reset and low
    wire        lvr_qual;               // Low supply lasted long enough
    wire        lvr_fire;               // Low-voltage reset now
    wire        wdt_full;               // Watchdog reset in normal mode
    wire        wdt_sleep;              // Watchdog reset in sleep or idle
    wire        full_evt;               // Any delayed full reset
    wire        apb_acc;                // Access phase
    wire        apb_wr;                 // Write takes effect
    wire        hit_sel;                // Pin select addressed
    wire        hit_system_mode_control_1;              // Mode control addressed
    wire        hit_sts;                // Status addressed
    wire        pin_release;            // Pin reset just ended

    // Start-up timer shared by all sources
    startup_timer u_startup_timer (
        .clk        (pclk),
        .rst_n      (presetn),
        .start      (tmr_start_ff),
        .load_value (tmr_load_ff),
        .done       (tmr_done)
    );

    // Pin only acts as reset under its key
    assign pin_low = (pin_sel_ff == `PSEL_KEY_RES) & ~external_reset_pin_n;
    assign pin_release = (state_ff == ST_PIN) & ~pin_low;

    // Long enough low supply is qualified
    assign lvr_qual = lvr_en_ff & supply_low & (lvr_cnt_ff >= LVR_QUAL_CYC);

    // Reset fires on the second tick after qualify
    assign lvr_fire = (state_ff == ST_LVRW) & low_speed_rc_tick &
                      (lvr_tick_ff == (`LVR_TICKS - 2'h1));

    // Watchdog time-out split by power mode
    assign wdt_full  = watchdog_timeout & ~sleep_idle_mode;
    assign wdt_sleep = watchdog_timeout & sleep_idle_mode & (state_ff == ST_RUN);

    // Sources that end in a start-up delay
    assign full_evt = lvr_fire | wdt_full | watchdog_ctrl_soft_reset;

    // State and timer load selection
    always @* begin
        nxt_state = state_ff;
        nxt_start = 1'b0;
        nxt_load  = tmr_load_ff;
        if (pin_low) begin
            // Pin held low overrides everything
            nxt_state = ST_PIN;
        end else if (full_evt) begin
            // Low-voltage and watchdog restart the delay
            nxt_state = ST_DELAY;
            nxt_start = 1'b1;
            nxt_load  = lvr_fire ? POR_DELAY_CYC : PIN_DELAY_CYC;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    // Running, watch the supply
                    if (lvr_qual) begin
                        nxt_state = ST_LVRW;
                    end
                end
                ST_PIN: begin
                    // Pin released, extra delay
                    nxt_state = ST_DELAY;
                    nxt_start = 1'b1;
                    nxt_load  = por_pending_ff ? POR_DELAY_CYC : PIN_DELAY_CYC;
                end
                ST_DELAY: begin
                    if (por_pending_ff) begin
                        // First cycle after power-on
                        nxt_start = 1'b1;
                        nxt_load  = POR_DELAY_CYC;
                    end else if (lvr_qual) begin
                        nxt_state = ST_LVRW;
                    end else if (tmr_done) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_LVRW: begin
                    // Qualified, wait for the ticks
                    nxt_state = ST_LVRW;
                end
                default: begin
                    nxt_state = ST_DELAY;
                end
            endcase
        end
    end

    // Sequencer registers and reset outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff       <= ST_DELAY;
            por_pending_ff <= 1'b1;
            tmr_start_ff   <= 1'b0;
            tmr_load_ff    <= 24'h000000;
            core_hold_ff   <= 1'b1;
            cold_reset_ff  <= 1'b1;
            pc_sp_clear_ff <= 1'b1;
            wdt_restart_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            tmr_start_ff <= nxt_start;
            tmr_load_ff  <= nxt_load;
            // Pending ends once a delay is loaded
            if (nxt_start) begin
                por_pending_ff <= 1'b0;
            end
            // Hold through pin, delay, and wait from delay
            core_hold_ff <= (nxt_state == ST_PIN) | (nxt_state == ST_DELAY) |
                            ((nxt_state == ST_LVRW) & core_hold_ff);
            // Cold state only until the first release
            if (nxt_state == ST_RUN) begin
                cold_reset_ff <= 1'b0;
            end
            // PC and SP cleared on every reset entry
            pc_sp_clear_ff <= full_evt | wdt_sleep |
                              (pin_low & (state_ff != ST_PIN));
            // Watchdog restarts at release
            wdt_restart_ff <= (state_ff != ST_RUN) & (nxt_state == ST_RUN);
        end
    end

    // Supply monitor enable and qualify counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_en_ff   <= 1'b1;
            lvr_cnt_ff  <= 24'h000000;
            lvr_tick_ff <= 2'h0;
        end else begin
            // On in normal and slow, off in sleep
            lvr_en_ff <= ~sleep_idle_mode;
            // Short dips restart the count
            if (!lvr_en_ff || !supply_low || (state_ff == ST_LVRW)) begin
                lvr_cnt_ff <= 24'h000000;
            end else if (lvr_cnt_ff < LVR_QUAL_CYC) begin
                lvr_cnt_ff <= lvr_cnt_ff + 24'h000001;
            end
            // Count ticks while waiting
            if (state_ff != ST_LVRW) begin
                lvr_tick_ff <= 2'h0;
            end else if (low_speed_rc_tick) begin
                lvr_tick_ff <= lvr_tick_ff + 2'h1;
            end
        end
    end

    // APB decode
    assign apb_acc   = psel & penable;
    assign apb_wr    = apb_acc & pwrite & pready_ff;
    assign hit_sel   = (paddr == `OFS_PIN_SEL);
    assign hit_system_mode_control_1 = (paddr == `OFS_SYSTEM_MODE_CONTROL_1);
    assign hit_sts   = (paddr == `OFS_STATUS);

    // Reset pin select register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sel_ff      <= `PSEL_RST;
            pin_is_reset_ff <= 1'b0;
        end else if (full_evt | pin_release) begin
            // Restored by all but sleep watchdog
            pin_sel_ff      <= `PSEL_RST;
            pin_is_reset_ff <= 1'b0;
        end else if (apb_wr & hit_sel) begin
            // Every bit writable, so both keys can be reached
            pin_sel_ff <= (pwdata[7:0] & `PSEL_WMASK) | (pin_sel_ff & ~`PSEL_WMASK);
            pin_is_reset_ff <= ((pwdata[7:0] & `PSEL_WMASK) |
                                (pin_sel_ff & ~`PSEL_WMASK)) == `PSEL_KEY_RES;
        end
    end

    // System mode control 1, flags set over clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_mode_control_1_ff <= `SM1_RST;
        end else begin
            if (apb_wr & hit_system_mode_control_1) begin
                // Plain bits 7 and 3
                system_mode_control_1_ff[7] <= pwdata[7];
                system_mode_control_1_ff[3] <= pwdata[3];
            end
            // Low-voltage flag: set by reset, clear-only
            if (lvr_fire) begin
                system_mode_control_1_ff[`SM1_LOW_VOLTAGE_RESET_FLAG] <= 1'b1;
            end else if (apb_wr & hit_system_mode_control_1) begin
                system_mode_control_1_ff[`SM1_LOW_VOLTAGE_RESET_FLAG] <= system_mode_control_1_ff[`SM1_LOW_VOLTAGE_RESET_FLAG] & pwdata[`SM1_LOW_VOLTAGE_RESET_FLAG];
            end
            // Soft reset flag: set by control reset, clear-only
            if (watchdog_ctrl_soft_reset) begin
                system_mode_control_1_ff[`SM1_WRF] <= 1'b1;
            end else if (apb_wr & hit_system_mode_control_1) begin
                system_mode_control_1_ff[`SM1_WRF] <= system_mode_control_1_ff[`SM1_WRF] & pwdata[`SM1_WRF];
            end
            // Unimplemented bits stay zero
            system_mode_control_1_ff[6:4] <= 3'h0;
            system_mode_control_1_ff[1]   <= 1'b0;
        end
    end

    // Time-out and power-down flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Power-on clears both
            to_flag_ff  <= 1'b0;
            pdf_flag_ff <= 1'b0;
        end else begin
            // Time-out set by either watchdog reset
            if (watchdog_timeout) begin
                to_flag_ff <= 1'b1;
            end else if (halt_exec | clear_wdt_exec) begin
                to_flag_ff <= 1'b0;
            end
            // Power-down set by halt or sleep time-out
            if (halt_exec | wdt_sleep) begin
                pdf_flag_ff <= 1'b1;
            end else if (clear_wdt_exec) begin
                pdf_flag_ff <= 1'b0;
            end
        end
    end

    // Read data source
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_sel) begin
            rd_mux[7:0] = pin_sel_ff;
        end else if (hit_system_mode_control_1) begin
            rd_mux[7:0] = system_mode_control_1_ff;
        end else if (hit_sts) begin
            rd_mux[`STS_TO]      = to_flag_ff;
            rd_mux[`STS_PDF]     = pdf_flag_ff;
            rd_mux[`STS_PIN_RES] = (pin_sel_ff == `PSEL_KEY_RES);
            rd_mux[`STS_LVR_EN]  = lvr_en_ff;
            rd_mux[`STS_HOLD]    = core_hold_ff;
        end
    end

    // APB answer one cycle into the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= apb_acc & ~pready_ff;
            pslverr_ff <= apb_acc & ~pready_ff & ~(hit_sel | hit_system_mode_control_1 | hit_sts);
            if (apb_acc & ~pready_ff & ~pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    // Outputs straight from registers
    assign prdata                = prdata_ff;
    assign pready                = pready_ff;
    assign pslverr               = pslverr_ff;
    assign core_hold             = core_hold_ff;
    assign cold_reset            = cold_reset_ff;
    assign pc_sp_clear           = pc_sp_clear_ff;
    assign wdt_restart           = wdt_restart_ff;
    assign lvr_monitor_en        = lvr_en_ff;
    assign pin_is_reset          = pin_is_reset_ff;
    assign watchdog_timeout_flag = to_flag_ff;
    assign power_down_flag       = pdf_flag_ff;

endmodule

`default_nettype wire

//--- tb/mcu_reset_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none

module mcu_reset_props #(
    parameter [23:0] POR_DELAY_CYC = 24'h14
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and events
    input wire logic        external_reset_pin_n,
    input wire logic        supply_low,
    input wire logic        sleep_idle_mode,
    input wire logic        watchdog_timeout,
    // Reset outputs
    input wire logic        core_hold,
    input wire logic        cold_reset,
    input wire logic        pc_sp_clear,
    input wire logic        wdt_restart,
    input wire logic        lvr_monitor_en,
    input wire logic        pin_is_reset,
    input wire logic        watchdog_timeout_flag,
    input wire logic        power_down_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Cycles of hold with no outside source still active
    logic [23:0] hold_cnt_ff;
    wire  [23:0] nxt_hold_cnt;
    assign nxt_hold_cnt = (core_hold && !supply_low && !(pin_is_reset && !external_reset_pin_n))
        ? hold_cnt_ff + 24'h1 : 24'h0;

    // Hold length counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_ff <= 24'h0;
        end else begin
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end

    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready too long");
    a_err_zero_data: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("bad error answer");
    a_unimpl_zero: assert property (
        pready && !pwrite && paddr == 8'h04 |-> prdata[6:4] == 3'h0 && !prdata[1])
        else $error("unimplemented bits set");
    a_pin_holds: assert property (pin_is_reset && !external_reset_pin_n |=> core_hold)
        else $error("pin low without hold");
    a_restart_on_release: assert property ($fell(core_hold) |-> wdt_restart)
        else $error("no watchdog restart");
    a_cold_stays_off: assert property (!cold_reset |=> !cold_reset)
        else $error("cold reset reasserted");
    a_monitor_off: assert property (sleep_idle_mode |=> !lvr_monitor_en)
        else $error("monitor on in sleep");
    a_monitor_on: assert property (!sleep_idle_mode |=> lvr_monitor_en)
        else $error("monitor off when running");
    a_wdt_normal_hold: assert property (
        watchdog_timeout && !sleep_idle_mode && !core_hold |=> core_hold)
        else $error("watchdog did not hold");
    a_sleep_wdt_clear: assert property (
        watchdog_timeout && sleep_idle_mode && !core_hold |=> pc_sp_clear && !core_hold)
        else $error("sleep watchdog wrong");
    a_sleep_wdt_flags: assert property (
        watchdog_timeout && sleep_idle_mode && !core_hold
        |-> ##[1:2] watchdog_timeout_flag && power_down_flag)
        else $error("sleep watchdog flags");
    a_hold_bounded: assert property (hold_cnt_ff <= POR_DELAY_CYC + 24'h8)
        else $error("hold too long");
endmodule

bind mcu_reset_sequencer mcu_reset_props #(.POR_DELAY_CYC(POR_DELAY_CYC)) u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .external_reset_pin_n, .supply_low, .sleep_idle_mode, .watchdog_timeout,
    .core_hold, .cold_reset, .pc_sp_clear, .wdt_restart, .lvr_monitor_en,
    .pin_is_reset, .watchdog_timeout_flag, .power_down_flag
);

`default_nettype wire

//--- tb/supply_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module supply_pin_model (
    // Clock
    input  wire logic pclk,
    // Bench requests
    input  wire logic pin_pull,
    input  wire logic brownout,
    // Toward the block
    output var  logic external_reset_pin_n,
    output var  logic supply_low,
    output var  logic low_speed_rc_tick
);
    logic [2:0] rc_div_ff; // Slow RC divider
    logic [1:0] cap_ff;    // Pin recharge time

    initial begin
        rc_div_ff = 3'h0;
        cap_ff = 2'h3;
        external_reset_pin_n = 1'h1;
        supply_low = 1'h0;
        low_speed_rc_tick = 1'h0;
    end

    // Tick, supply level and RC pin charge
    always @(posedge pclk) begin
        rc_div_ff <= rc_div_ff + 3'h1;
        low_speed_rc_tick <= (rc_div_ff == 3'h7);
        supply_low <= brownout;
        cap_ff <= pin_pull ? 2'h0 : ((cap_ff == 2'h3) ? 2'h3 : cap_ff + 2'h1);
        external_reset_pin_n <= !pin_pull && (cap_ff == 2'h3);
    end
endmodule

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [23:0] POR = 24'h14;
    localparam logic [23:0] PIN = 24'h0A;
    localparam logic [23:0] QUAL = 24'h05;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
    // Register rows: direction, address, data, expected read, expected error
    row_t rows [0:11] = '{
        '{1'h0, 8'h00, 32'h00, 32'h55, 1'h0}, '{1'h0, 8'h04, 32'h00, 32'h00, 1'h0},
        '{1'h1, 8'h04, 32'hFF, 32'h00, 1'h0}, '{1'h0, 8'h04, 32'h00, 32'h88, 1'h0},
        '{1'h1, 8'h08, 32'hFF, 32'h00, 1'h0}, '{1'h0, 8'h0C, 32'h00, 32'h00, 1'h1},
        '{1'h1, 8'h0C, 32'h12, 32'h00, 1'h1}, '{1'h1, 8'h00, 32'hFF, 32'h00, 1'h0},
        '{1'h0, 8'h00, 32'h00, 32'hFF, 1'h0}, '{1'h1, 8'h00, 32'hAA, 32'h00, 1'h0},
        '{1'h0, 8'h00, 32'h00, 32'hAA, 1'h0}, '{1'h0, 8'h08, 32'h00, 32'h0C, 1'h0}};
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  ev = 4'h0;        // Timeout, soft reset, halt, clear
    logic        sleep_idle_mode = 1'h0;
    logic        pin_pull = 1'h0;
    logic        brownout = 1'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, external_reset_pin_n, supply_low, low_speed_rc_tick;
    wire         core_hold, cold_reset, pc_sp_clear, wdt_restart, lvr_monitor_en;
    wire         pin_is_reset, watchdog_timeout_flag, power_down_flag;
    int          n_fail = 0;
    int          comparisons = 0;
    int          n;

    always #2 pclk = ~pclk;

    mcu_reset_sequencer #(.POR_DELAY_CYC(POR), .PIN_DELAY_CYC(PIN), .LVR_QUAL_CYC(QUAL)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .external_reset_pin_n, .supply_low, .low_speed_rc_tick, .sleep_idle_mode,
        .watchdog_timeout(ev[0]), .watchdog_ctrl_soft_reset(ev[1]), .halt_exec(ev[2]),
        .clear_wdt_exec(ev[3]), .core_hold, .cold_reset, .pc_sp_clear, .wdt_restart,
        .lvr_monitor_en, .pin_is_reset, .watchdog_timeout_flag, .power_down_flag);

    supply_pin_model far (.pclk, .pin_pull, .brownout, .external_reset_pin_n, .supply_low,
        .low_speed_rc_tick);

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, x, g);
        end
    endtask

    // One bus transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        q = prdata;
        e = pslverr;
        chk("answer", 32'h1, {31'h0, k < 50});
        if (k >= 50) print_verdict;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'h1, a, d, q, e);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'h0, a, 32'h0, q, e);
        chk(nm, x, q);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'h1;
        @(posedge pclk);
        ev[i] <= 1'h0;
    endtask

    // Count edges until the hold reaches the given level
    task automatic wait_lvl(input logic v, output int k);
        k = 0;
        while (core_hold !== v && k < 200) begin
            @(posedge pclk);
            k++;
        end
    endtask

    task automatic rng(input string nm, input int k, input int lo, input int hi);
        chk(nm, 32'h1, {31'h0, k >= lo && k <= hi});
    endtask

    // No hold may appear for a while
    task automatic quiet(input int c);
        logic seen;
        seen = 1'h0;
        repeat (c) begin
            @(posedge pclk);
            seen = seen | core_hold;
        end
        chk("no_hold", 32'h0, {31'h0, seen});
    endtask

    task automatic flags(input logic [1:0] x);
        chk("flags", {30'h0, x}, {30'h0, watchdog_timeout_flag, power_down_flag});
    endtask

    // Watchdog on a hang
    initial begin
        #40000;
        n_fail++;
        print_verdict;
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk("por_hold", 32'h1, {31'h0, core_hold});
        wait_lvl(1'h0, n);
        rng("por_delay", n, POR, POR + 4);
        repeat (2) @(posedge pclk);
        chk("cold", 32'h0, {31'h0, cold_reset});
        flags(2'h0);
        foreach (rows[i]) begin
            logic [31:0] q;
            logic e;
            apb(rows[i].wr, rows[i].a, rows[i].d, q, e);
            if (!rows[i].wr) chk("rdata", rows[i].q, q);
            chk("pslverr", {31'h0, rows[i].e}, {31'h0, e});
        end
        chk("pin_is_reset", 32'h1, {31'h0, pin_is_reset});
        // Pin reset while running
        pin_pull <= 1'h1;
        repeat (5) @(posedge pclk);
        chk("pin_hold", 32'h1, {31'h0, core_hold});
        pin_pull <= 1'h0;
        repeat (6) @(posedge pclk);
        wait_lvl(1'h0, n);
        rng("pin_delay", n, PIN - 4, PIN + 4);
        rdc("sel_restored", 8'h00, 32'h55);
        rdc("mode_kept", 8'h04, 32'h88);
        // Low supply: short glitch then a real drop
        brownout <= 1'h1;
        repeat (3) @(posedge pclk);
        brownout <= 1'h0;
        quiet(30);
        brownout <= 1'h1;
        wait_lvl(1'h1, n);
        brownout <= 1'h0;
        rng("lvr_entry", n, QUAL, QUAL + 24);
        wait_lvl(1'h0, n);
        rdc("lvr_flag", 8'h04, 32'h8C);
        flags(2'h0);
        wr(8'h04, 32'h88);
        wr(8'h04, 32'h8C);
        rdc("lvr_clear", 8'h04, 32'h88);
        // Sleep: monitor off, watchdog warm reset
        sleep_idle_mode <= 1'h1;
        brownout <= 1'h1;
        quiet(40);
        brownout <= 1'h0;
        wr(8'h00, 32'hAA);
        pulse(2);
        pulse(0);
        quiet(10);
        flags(2'h3);
        rdc("sel_warm", 8'h00, 32'hAA);
        sleep_idle_mode <= 1'h0;
        pulse(3);
        @(posedge pclk);
        flags(2'h0);
        // Watchdog while running
        pulse(0);
        wait_lvl(1'h1, n);
        rng("wdt_entry", n, 0, 2);
        wait_lvl(1'h0, n);
        rng("wdt_delay", n, PIN, PIN + 4);
        flags(2'h2);
        rdc("sel_wdt", 8'h00, 32'h55);
        pulse(1);
        wait_lvl(1'h1, n);
        wait_lvl(1'h0, n);
        rdc("soft_flag", 8'h04, 32'h89);
        // Second power-on reset mid-run
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rdc("mode_por", 8'h04, 32'h00);
        chk("cold_again", 32'h1, {31'h0, cold_reset});
        flags(2'h0);
        print_verdict;
    end
endmodule

`default_nettype wire
